// file: adc_pkg.sv
// Constants, encodings and state types shared by the converter control block
package adc_pkg;

    // Register byte addresses on the bus, one aligned word each
    localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h0C;

    // Field positions inside the status and control register
    localparam int STAT_COMPLETE_BIT = 7;
    // Field positions inside the clock configuration register
    localparam int CLK_ASYNC_BIT = 0;
    localparam int CLK_FULL_BIT = 2;
    localparam int CLK_LONG_BIT = 4;
    localparam int CLK_DIV_LSB = 5;
    localparam int CLK_DIV_MSB = 6;

    // Channel select codes
    localparam logic [4:0] LEGACY_CHANNELS = 5'h04;
    localparam logic [4:0] CH_PORT_B_PIN_ZERO = 5'h04;
    localparam logic [4:0] CH_PORT_B_PIN_ONE = 5'h05;
    localparam logic [4:0] CH_BANDGAP = 5'h1A;
    localparam logic [4:0] CH_OFF = 5'h1F;

    // Reset values
    localparam logic [4:0] CHANNEL_RESET = 5'h1F;
    localparam logic [1:0] DIVSEL_RESET = 2'h0;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // Sampling lengths in reference clock ticks, minus one
    localparam logic [4:0] SAMPLE_SHORT_LAST = 5'h03;
    localparam logic [4:0] SAMPLE_LONG_LAST = 5'h17;
    // Approximation bit indices
    localparam logic [3:0] MSB_INDEX = 4'h9;
    localparam logic [3:0] FULL_LAST_BIT = 4'h0;
    localparam logic [3:0] REDUCED_LAST_BIT = 4'h2;
    // Internal asynchronous oscillator modelled as one tick per eight cycles
    localparam logic [2:0] ASYNC_DIV_LAST = 3'h7;

    // Sequencer states
    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00,
        SAR_SAMPLE = 2'b01,
        SAR_CONVERT = 2'b10
    } sar_state_t;

    // Whole state of the approximation sequencer
    typedef struct packed {
        sar_state_t state;
        logic [4:0] cnt;
        logic [3:0] bit_idx;
        logic [9:0] code;
        logic [9:0] result;
        logic done;
        logic full;
        logic long_smp;
    } sar_regs_t;

    // Whole state of the control block
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic [4:0] channel;
        logic complete;
        logic [1:0] divsel;
        logic long_sample;
        logic full_mode;
        logic async_en;
        logic [9:0] result;
        logic [3:0] div_cnt;
        logic [2:0] async_cnt;
    } ctrl_regs_t;

endpackage : adc_pkg

// file: sar_sequencer.sv
// Successive approximation sequencer: sampling phase then bit trials
`timescale 1ns/1ps
module sar_sequencer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control from the register block
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic full_mode_i,
    input wire logic long_sample_i,
    // Analog front end
    input wire logic comparator_i,
    output logic [9:0] dac_code_o,
    // Results
    output logic [9:0] result_o,
    output logic done_o,
    output logic busy_o
);

    // Current and next state
    adc_pkg::sar_regs_t s;
    adc_pkg::sar_regs_t next_s;

    // Last bit to trial and last sampling tick, fixed at start
    logic [3:0] last_bit;
    logic [4:0] sample_last;

    assign last_bit = s.full ? adc_pkg::FULL_LAST_BIT : adc_pkg::REDUCED_LAST_BIT; // see (R1)
    assign sample_last = s.long_smp ? adc_pkg::SAMPLE_LONG_LAST : adc_pkg::SAMPLE_SHORT_LAST; // see (R6)

    // Sequencer next state
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.state)
            adc_pkg::SAR_IDLE:
            begin
                // Waiting for a start
            end
            adc_pkg::SAR_SAMPLE:
            begin
                // Hold the input on the sample capacitor
                if (tick_i)
                begin
                    if (s.cnt == sample_last) // see (R6)
                    begin
                        next_s.state = adc_pkg::SAR_CONVERT;
                        next_s.bit_idx = adc_pkg::MSB_INDEX;
                        next_s.code[adc_pkg::MSB_INDEX] = 1'b1;
                    end
                    else
                    begin
                        next_s.cnt = s.cnt + 5'h01;
                    end
                end
            end
            adc_pkg::SAR_CONVERT:
            begin
                // Keep the trial bit if the input is at or above the trial level
                if (tick_i)
                begin
                    next_s.code[s.bit_idx] = comparator_i;
                    if (s.bit_idx == last_bit) // see (R1)
                    begin
                        next_s.state = adc_pkg::SAR_IDLE;
                        next_s.done = 1'b1;
                        next_s.result = next_s.code;
                    end
                    else
                    begin
                        next_s.bit_idx = s.bit_idx - 4'h1;
                        next_s.code[s.bit_idx - 4'h1] = 1'b1;
                    end
                end
            end
            default:
            begin
                // Illegal code falls back to idle
                next_s.state = adc_pkg::SAR_IDLE;
            end
        endcase
        // Start restarts even mid conversion; mode is latched here
        if (start_i)
        begin
            next_s.state = adc_pkg::SAR_SAMPLE;
            next_s.cnt = 5'h00;
            next_s.code = adc_pkg::RESULT_RESET;
            next_s.full = full_mode_i;
            next_s.long_smp = long_sample_i;
        end
        else if (abort_i)
        begin
            next_s.state = adc_pkg::SAR_IDLE;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign dac_code_o = s.code;
    assign result_o = s.result;
    assign done_o = s.done;
    assign busy_o = (s.state != adc_pkg::SAR_IDLE);

    // Reduced mode never fills the two lowest bits
    a_reduced_width: assert property (@(posedge clk_i) disable iff (rst_i) // see (R1)
        s.done && !s.full |-> s.result[1:0] == 2'b00)
        else $error("reduced result has low bits set");

    // Sampling lasts the selected number of ticks
    a_sample_length: assert property (@(posedge clk_i) disable iff (rst_i) // see (R6)
        $past(s.state) == adc_pkg::SAR_SAMPLE && s.state == adc_pkg::SAR_CONVERT
        |-> $past(s.cnt) == ($past(s.long_smp) ? adc_pkg::SAMPLE_LONG_LAST : adc_pkg::SAMPLE_SHORT_LAST))
        else $error("sampling phase length wrong");

endmodule : sar_sequencer

// file: adc_control_10bit.sv
// Register block, clock selection and channel decode of the converter
`timescale 1ns/1ps
// Summary of operation
// (R1) Ten-bit or eight-bit result width selectable
// (R2) Top result bits sit low in high register
// (R3) Channel select leaves pin digital function alone
// (R4) Reference clock: fast system clock or asynchronous
// (R5) Asynchronous clock keeps converting in stop mode
// (R6) Long sample bit lengthens sampling phase
// (R7) Channel field decodes extra inputs and bandgap
// (R8) Two extra channels on port B pins
// (R9) Code 1A routes bandgap to converter
// (R10) Eight-bit mode: full result low, high zero
module adc_control_10bit (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Processor power state
    input wire logic stop_mode_i,
    // Analog front end
    input wire logic comparator_i,
    output logic [9:0] dac_code_o,
    output logic [4:0] channel_select_bits_o,
    output logic port_b_pin_zero_sel_o,
    output logic port_b_pin_one_sel_o,
    output logic bandgap_sel_o,
    output logic legacy_sel_o,
    // Status
    output logic conversion_active_o
);

    // Current and next state
    adc_pkg::ctrl_regs_t s;
    adc_pkg::ctrl_regs_t next_s;

    // Bus decode
    logic req;
    logic wr_lane;
    logic wr_status;
    logic wr_clock;
    logic rd_low;
    // Reference clock ticks
    logic [3:0] div_last;
    logic bus_tick;
    logic async_tick;
    logic ref_tick;
    // Sequencer handshake
    logic start;
    logic abort;
    logic [9:0] sar_result;
    logic sar_done;
    logic sar_busy;

    // A new request is seen only while no answer is pending
    assign req = wb_cyc_i && wb_stb_i && !s.ack;
    assign wr_lane = req && wb_we_i && wb_sel_i[0];
    assign wr_status = wr_lane && (wb_adr_i == adc_pkg::ADDR_STATUS_CONTROL);
    assign wr_clock = wr_lane && (wb_adr_i == adc_pkg::ADDR_CLOCK_CONFIG);
    assign rd_low = req && !wb_we_i && (wb_adr_i == adc_pkg::ADDR_RESULT_LOW);

    // Writing a live channel starts a conversion, the off code stops one
    assign start = wr_status && (wb_dat_i[4:0] != adc_pkg::CH_OFF);
    assign abort = wr_status && (wb_dat_i[4:0] == adc_pkg::CH_OFF);

    // Fast clock divider: one tick every 1, 2, 4 or 8 block clock cycles as divsel selects
    assign div_last = 4'((4'h1 << s.divsel) - 4'h1);
    assign bus_tick = (s.div_cnt == div_last); // see (R4)
    // Stand-in for the converter's own oscillator, free running
    assign async_tick = (s.async_cnt == adc_pkg::ASYNC_DIV_LAST); // see (R4)
    // Stop mode freezes the fast clock; only the asynchronous one survives it
    assign ref_tick = s.async_en ? async_tick : (bus_tick && !stop_mode_i); // see (R4) (R5)

    // Register and divider next state
    always_comb
    begin
        next_s = s;
        next_s.ack = req;
        next_s.div_cnt = bus_tick ? 4'h0 : s.div_cnt + 4'h1;
        next_s.async_cnt = s.async_cnt + 3'h1;
        // Read data, narrow registers in the low byte
        next_s.rdata = 8'h00;
        if (req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                adc_pkg::ADDR_STATUS_CONTROL:
                begin
                    next_s.rdata[4:0] = s.channel;
                    next_s.rdata[adc_pkg::STAT_COMPLETE_BIT] = s.complete;
                end
                adc_pkg::ADDR_CLOCK_CONFIG:
                begin
                    next_s.rdata[adc_pkg::CLK_ASYNC_BIT] = s.async_en;
                    next_s.rdata[adc_pkg::CLK_FULL_BIT] = s.full_mode;
                    next_s.rdata[adc_pkg::CLK_LONG_BIT] = s.long_sample;
                    next_s.rdata[adc_pkg::CLK_DIV_MSB:adc_pkg::CLK_DIV_LSB] = s.divsel;
                end
                adc_pkg::ADDR_RESULT_HIGH:
                begin
                    // Upper six bits stay zero; eight-bit mode reads all zero
                    next_s.rdata[1:0] = s.full_mode ? s.result[9:8] : 2'b00; // see (R2) (R10)
                end
                adc_pkg::ADDR_RESULT_LOW:
                begin
                    next_s.rdata = s.full_mode ? s.result[7:0] : s.result[9:2]; // see (R1) (R10)
                end
                default:
                begin
                    // Unmapped address answers with zero
                    next_s.rdata = 8'h00;
                end
            endcase
        end
        // Channel select write
        if (wr_status)
        begin
            next_s.channel = wb_dat_i[4:0]; // see (R7)
        end
        // Clock configuration write
        if (wr_clock)
        begin
            next_s.async_en = wb_dat_i[adc_pkg::CLK_ASYNC_BIT]; // see (R5)
            next_s.full_mode = wb_dat_i[adc_pkg::CLK_FULL_BIT]; // see (R1)
            next_s.long_sample = wb_dat_i[adc_pkg::CLK_LONG_BIT]; // see (R6)
            next_s.divsel = wb_dat_i[adc_pkg::CLK_DIV_MSB:adc_pkg::CLK_DIV_LSB];
        end
        // Complete flag: cleared by a new start or a low result read, set wins
        if (start || rd_low)
        begin
            next_s.complete = 1'b0;
        end
        if (sar_done)
        begin
            next_s.complete = 1'b1;
            next_s.result = sar_result;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.channel <= adc_pkg::CHANNEL_RESET;
            s.divsel <= adc_pkg::DIVSEL_RESET;
            s.result <= adc_pkg::RESULT_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Approximation sequencer
    sar_sequencer u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(ref_tick),
        .start_i(start),
        .abort_i(abort),
        .full_mode_i(s.full_mode),
        .long_sample_i(s.long_sample),
        .comparator_i(comparator_i),
        .dac_code_o(dac_code_o),
        .result_o(sar_result),
        .done_o(sar_done),
        .busy_o(sar_busy)
    );

    // Input mux decode; only analog select lines leave here, pin direction stays with the port
    assign channel_select_bits_o = s.channel; // see (R3)
    assign legacy_sel_o = (s.channel < adc_pkg::LEGACY_CHANNELS); // see (R7)
    assign port_b_pin_zero_sel_o = (s.channel == adc_pkg::CH_PORT_B_PIN_ZERO); // see (R8)
    assign port_b_pin_one_sel_o = (s.channel == adc_pkg::CH_PORT_B_PIN_ONE); // see (R8)
    assign bandgap_sel_o = (s.channel == adc_pkg::CH_BANDGAP); // see (R9)

    // Bus outputs
    assign wb_ack_o = s.ack;
    assign wb_dat_o = {24'h000000, s.rdata};
    assign conversion_active_o = sar_busy;

    // High register read never shows the upper six bits
    a_high_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) // see (R2)
        req && !wb_we_i && wb_adr_i == adc_pkg::ADDR_RESULT_HIGH |=> wb_ack_o && wb_dat_o[7:2] == 6'h00)
        else $error("high result upper bits not zero");

    // Eight-bit mode high register reads zero
    a_reduced_high_zero: assert property (@(posedge clk_i) disable iff (rst_i) // see (R10)
        req && !wb_we_i && !s.full_mode && wb_adr_i == adc_pkg::ADDR_RESULT_HIGH |=> wb_dat_o[7:0] == 8'h00)
        else $error("high result not zero in eight-bit mode");

    // Full mode high register carries result bits nine and eight
    a_full_high_bits: assert property (@(posedge clk_i) disable iff (rst_i) // see (R1)
        req && !wb_we_i && s.full_mode && wb_adr_i == adc_pkg::ADDR_RESULT_HIGH && !sar_done
        |=> wb_dat_o[1:0] == s.result[9:8])
        else $error("high result bits wrong in ten-bit mode");

    // Asynchronous source paces the ticks at its own rate, whatever the divider does
    a_async_source: assert property (@(posedge clk_i) disable iff (rst_i) // see (R4)
        s.async_en && ref_tick |=> (!ref_tick || !s.async_en) [*7])
        else $error("reference tick not from asynchronous source");

    // Fast clock source stops in stop mode
    a_stop_halts: assert property (@(posedge clk_i) disable iff (rst_i) // see (R5)
        stop_mode_i && !s.async_en |-> !ref_tick)
        else $error("fast clock ticked in stop mode");

    // Asynchronous ticks keep coming in stop mode
    a_stop_async_runs: assert property (@(posedge clk_i) disable iff (rst_i) // see (R5)
        stop_mode_i && s.async_en && async_tick |-> ref_tick)
        else $error("asynchronous clock halted in stop mode");

    // Extra channel and bandgap selects are exclusive of legacy
    a_legacy_route: assert property (@(posedge clk_i) disable iff (rst_i) // see (R7)
        legacy_sel_o |-> !port_b_pin_zero_sel_o && !port_b_pin_one_sel_o && !bandgap_sel_o)
        else $error("legacy and extra channel both selected");

    // A write of the second port B pin code routes that pin next cycle
    a_port_b_route: assert property (@(posedge clk_i) disable iff (rst_i) // see (R8)
        wr_status && wb_dat_i[4:0] == adc_pkg::CH_PORT_B_PIN_ONE |=> port_b_pin_one_sel_o && !bandgap_sel_o)
        else $error("port B channel not routed");

    // Bandgap code routes the reference
    a_bandgap_route: assert property (@(posedge clk_i) disable iff (rst_i) // see (R9)
        wr_status && wb_dat_i[4:0] == adc_pkg::CH_BANDGAP |=> bandgap_sel_o && conversion_active_o)
        else $error("bandgap not routed");

    // One ack per request
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : adc_control_10bit

// file: testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
    // Clock, reset and bus master signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    // Analog side and status
    logic stop_mode_i = 1'b0;
    logic comparator_i = 1'b0;
    logic [9:0] dac_code_o;
    logic [4:0] channel_select_bits_o;
    logic port_b_pin_zero_sel_o;
    logic port_b_pin_one_sel_o;
    logic bandgap_sel_o;
    logic legacy_sel_o;
    logic conversion_active_o;
    // Input voltage in codes, counters, scratch
    logic [9:0] analog = 10'h000;
    int err_count = 0;
    int cmp_count = 0;
    int act_cnt = 0;
    logic [31:0] rd;

    // Clock: 4 ns period
    always #2 clk_i = ~clk_i;

    // Comparator lags the trial code by one edge, so ticks must be slower than one cycle
    always @(posedge clk_i)
    begin
        comparator_i <= (analog >= dac_code_o);
        if (conversion_active_o === 1'b1)
            act_cnt <= act_cnt + 1;
    end

    adc_control_10bit adc_control_10bit_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .stop_mode_i(stop_mode_i), .comparator_i(comparator_i),
        .dac_code_o(dac_code_o), .channel_select_bits_o(channel_select_bits_o),
        .port_b_pin_zero_sel_o(port_b_pin_zero_sel_o), .port_b_pin_one_sel_o(port_b_pin_one_sel_o),
        .bandgap_sel_o(bandgap_sel_o), .legacy_sel_o(legacy_sel_o),
        .conversion_active_o(conversion_active_o)
    );

    // Verdict and end of run
    task results;
    begin
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask : results

    // Single comparison point; case inequality so unknowns never match
    task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask : check

    // Classic cycle: hold everything until ack is sampled, then release for one cycle
    task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
    begin
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1)
        begin
            err_count++;
            results();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    end
    endtask : wb_xfer

    task wr(input logic [7:0] adr, input logic [31:0] dat);
    begin
        wb_xfer(1'b1, adr, dat, rd);
    end
    endtask : wr

    // Read and compare; the caller's line names what is checked
    task rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    begin
        wb_xfer(1'b0, adr, 32'h0000_0000, rd);
        check(rd, exp);
    end
    endtask : rd_chk

    // Wait for the complete flag by polling, bounded
    task wait_done;
        int n;
    begin
        n = 0;
        do
        begin
            wb_xfer(1'b0, adc_pkg::ADDR_STATUS_CONTROL, 32'h0000_0000, rd);
            n++;
        end
        while (rd[adc_pkg::STAT_COMPLETE_BIT] !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            err_count++;
            results();
        end
    end
    endtask : wait_done

    // Start a conversion on the first port B pin and return active cycles spent
    task convert(input logic [9:0] v, output int cycles);
        int s;
    begin
        analog = v;
        s = act_cnt;
        wr(adc_pkg::ADDR_STATUS_CONTROL, 32'h0000_0004);
        wait_done();
        cycles = act_cnt - s;
    end
    endtask : convert

    // Reset values of the status, clock and high result registers and decode outputs
    task t_reset;
    begin
        rd_chk(adc_pkg::ADDR_RESULT_HIGH, 32'h0000_0000);
        rd_chk(adc_pkg::ADDR_CLOCK_CONFIG, 32'h0000_0000);
        rd_chk(adc_pkg::ADDR_STATUS_CONTROL, 32'h0000_001F);
        check({bandgap_sel_o, port_b_pin_one_sel_o, port_b_pin_zero_sel_o, legacy_sel_o}, 32'h0);
        check(conversion_active_o, 32'h0);
        check(dac_code_o, 32'h0);
    end
    endtask : t_reset

    // Every channel class, then abort through the off code
    task t_channels;
        logic [4:0] codes [7];
    begin
        codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1A};
        foreach (codes[i])
        begin
            wr(adc_pkg::ADDR_STATUS_CONTROL, {27'h0, codes[i]});
            check(channel_select_bits_o, {27'h0, codes[i]});
            check({bandgap_sel_o, port_b_pin_one_sel_o, port_b_pin_zero_sel_o, legacy_sel_o},
                {28'h0, codes[i] == 5'h1A, codes[i] == 5'h05, codes[i] == 5'h04, codes[i] < 5'h04});
        end
        check(bandgap_sel_o, 32'h1);
        wr(adc_pkg::ADDR_STATUS_CONTROL, 32'h0000_001F);
        check(conversion_active_o, 32'h0);
    end
    endtask : t_channels

    // Full, reduced and long-sample conversions, plus stop mode on both clocks
    task t_convert;
        int s;
        int l;
    begin
        wr(adc_pkg::ADDR_CLOCK_CONFIG, 32'h0000_0044);
        convert(10'h3FF, s);
        check(dac_code_o, 32'h0000_03FF);
        rd_chk(adc_pkg::ADDR_RESULT_HIGH, 32'h0000_0003);
        rd_chk(adc_pkg::ADDR_RESULT_LOW, 32'h0000_00FF);
        convert(10'h2B5, s);
        rd_chk(adc_pkg::ADDR_RESULT_HIGH, 32'h0000_0002);
        rd_chk(adc_pkg::ADDR_RESULT_LOW, 32'h0000_00B5);
        wr(adc_pkg::ADDR_CLOCK_CONFIG, 32'h0000_0054);
        convert(10'h2B5, l);
        check(l - s >= 76 && l - s <= 84, 32'h1);
        wr(adc_pkg::ADDR_CLOCK_CONFIG, 32'h0000_0040);
        convert(10'h2B5, l);
        rd_chk(adc_pkg::ADDR_RESULT_HIGH, 32'h0000_0000);
        rd_chk(adc_pkg::ADDR_RESULT_LOW, 32'h0000_00AD);
        // Fast clock is gated in stop mode, so the conversion must stall
        wr(adc_pkg::ADDR_CLOCK_CONFIG, 32'h0000_0044);
        stop_mode_i <= 1'b1;
        analog = 10'h155;
        wr(adc_pkg::ADDR_STATUS_CONTROL, 32'h0000_0005);
        repeat (100) @(posedge clk_i);
        check(conversion_active_o, 32'h1);
        rd_chk(adc_pkg::ADDR_STATUS_CONTROL, 32'h0000_0005);
        stop_mode_i <= 1'b0;
        wait_done();
        rd_chk(adc_pkg::ADDR_RESULT_LOW, 32'h0000_0055);
        // Asynchronous clock keeps running in stop mode
        wr(adc_pkg::ADDR_CLOCK_CONFIG, 32'h0000_0005);
        stop_mode_i <= 1'b1;
        convert(10'h1A6, l);
        rd_chk(adc_pkg::ADDR_RESULT_HIGH, 32'h0000_0001);
        rd_chk(adc_pkg::ADDR_RESULT_LOW, 32'h0000_00A6);
        stop_mode_i <= 1'b0;
        // Read-only high byte ignores writes; unmapped place reads zero
        wr(adc_pkg::ADDR_RESULT_HIGH, 32'h0000_00FF);
        rd_chk(adc_pkg::ADDR_RESULT_HIGH, 32'h0000_0001);
        rd_chk(8'h10, 32'h0000_0000);
    end
    endtask : t_convert

    // Main sequence with a hard stop against hangs
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_channels();
        t_convert();
        results();
    end

    initial
    begin
        #400000;
        err_count++;
        results();
    end
endmodule : testbench
